//--- verilog/dtam_alarm_manager.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module dtam_alarm_manager #(
    parameter int TICK_CYCLES = dtam_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire dtam_pkg::dtam_fault_in_t fault_i,
    input wire dtam_pkg::dtam_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    output logic healthy_o,
    output logic trip_o,
    output logic irq_o
);
    import dtam_pkg::*;

    localparam int FW = $bits(dtam_fault_in_t);

    logic [FW-1:0] fault_sync_bits;
    dtam_fault_in_t fs;
    logic [15:0] tick_cnt_reg;
    logic [15:0] tick_cnt_next;
    logic tick_reg;
    logic tick_next;
    logic stall_cond;
    logic stall_done;
    logic remote_done;
    logic run_prev_reg;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic fault_ready;
    logic field_low;
    logic [NUM_ALARMS-1:0] det_vec;
    logic [NUM_ALARMS-1:0] active_vec;
    logic [NUM_ALARMS-1:0] base_vec;
    logic [NUM_ALARMS-1:0] newly_vec;
    logic clr;
    logic trip_reset_reg;
    logic trip_reset_next;
    logic [NUM_ALARMS-1:0] inhibit_reg;
    logic [NUM_ALARMS-1:0] inhibit_next;
    logic [11:0] stall_thresh_reg;
    logic [11:0] stall_thresh_next;
    logic [15:0] stall_delay_reg;
    logic [15:0] stall_delay_next;
    logic [15:0] external_shutdown_delay_reg;
    logic [15:0] external_shutdown_delay_next;
    logic [NUM_ALARMS-1:0] latched_reg;
    logic [NUM_ALARMS-1:0] latched_next;
    logic [15:0] health_word_reg;
    logic [15:0] health_word_next;
    logic [15:0] first_reg;
    logic [15:0] first_next;
    logic first_valid_reg;
    logic first_valid_next;
    logic [15:0] last_reg;
    logic [15:0] last_next;
    logic healthy_reg;
    logic healthy_next;
    logic trip_reg;
    logic trip_next;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_status_next;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_enable_next;
    logic irq_reg;
    logic irq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // every detector pin arrives from outside this clock's domain
    dtam_sync #(
        .WIDTH(FW)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(fault_i),
        .q_o(fault_sync_bits)
    );
    assign fs = dtam_fault_in_t'(fault_sync_bits);
    // synchroniser shows zeros until filled; zero field current would read as a fault
    assign fault_ready = settle_reg[1];

    // delay prescaler: one tick per delay unit
    always_comb begin
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        settle_next = fault_ready ? settle_reg : settle_reg + 2'b01;
        tick_next = 1'b0;
        if (tick_cnt_reg >= 16'(TICK_CYCLES - 1)) begin
            tick_cnt_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
            run_prev_reg <= 1'b0;
            settle_reg <= 2'b00;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            run_prev_reg <= fs.run_input_terminal;
            settle_reg <= settle_next;
        end
    end

    assign stall_cond = (fs.armature_current > stall_thresh_reg) && fs.speed_zero
        && !fs.setpoint_zero;

    dtam_delay_timer #(
        .WIDTH(16)
    ) u_stall_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .cond_i(stall_cond),
        .tick_i(tick_reg),
        .limit_i(stall_delay_reg),
        .done_o(stall_done)
    );

    dtam_delay_timer #(
        .WIDTH(16)
    ) u_remote_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .cond_i(fs.raw_alarm[A_REMOTE]),
        .tick_i(tick_reg),
        .limit_i(external_shutdown_delay_reg),
        .done_o(remote_done)
    );

    assign field_low = fs.voltage_mode ? (fs.field_current_pct < FIELD_MIN_VOLT_PCT)
        : (fs.field_current_pct < FIELD_MIN_CUR_PCT);

    always_comb begin
        det_vec = fs.raw_alarm;
        det_vec[A_FIELD] = field_low;
        det_vec[A_ENCODER] = fs.raw_alarm[A_ENCODER] && fs.encoder_selected;
        det_vec[A_LINK] = fs.raw_alarm[A_LINK] && fs.link_slave;
        det_vec[A_STALL] = stall_done;
        det_vec[A_REMOTE] = remote_done;
        if (!fault_ready) begin
            det_vec = '0;
        end
    end

    assign active_vec = det_vec & ~inhibit_reg;
    // auto clear on run only with trip reset true; setting it true clears too
    assign clr = (trip_reset_reg && ((fs.run_input_terminal && !run_prev_reg)
        || (bus_i.wr && bus_i.addr == OFF_CTRL && bus_i.wdata[CTRL_SOFT_CLEAR])))
        || (bus_i.wr && bus_i.addr == OFF_CTRL && bus_i.wdata[CTRL_TRIP_RESET]
        && !trip_reset_reg);
    assign base_vec = clr ? '0 : latched_reg;
    assign newly_vec = active_vec & ~base_vec;

    always_comb begin
        latched_next = base_vec | active_vec;
        first_valid_next = clr ? 1'b0 : first_valid_reg;
        first_next = first_reg;
        last_next = last_reg;
        if (newly_vec != '0) begin
            last_next = dtam_pick_code(newly_vec);
            if (!first_valid_next) begin
                first_next = dtam_pick_code(newly_vec);
                first_valid_next = 1'b1;
            end
        end
        if (clr && newly_vec == '0) begin
            first_next = 16'h0000;
        end
        // inhibiting an alarm later also removes it from trip and health
        health_word_next = dtam_health_of(latched_next & ~inhibit_next);
        healthy_next = (latched_next & ~inhibit_next) == '0;
        trip_next = !healthy_next;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latched_reg <= '0;
            first_valid_reg <= 1'b0;
            first_reg <= 16'h0000;
            last_reg <= 16'h0000;
            health_word_reg <= 16'h0000;
            healthy_reg <= 1'b1;
            trip_reg <= 1'b0;
        end else begin
            latched_reg <= latched_next;
            first_valid_reg <= first_valid_next;
            first_reg <= first_next;
            last_reg <= last_next;
            health_word_reg <= health_word_next;
            healthy_reg <= healthy_next;
            trip_reg <= trip_next;
        end
    end

    // register file and interrupt logic
    always_comb begin
        trip_reset_next = trip_reset_reg;
        inhibit_next = inhibit_reg;
        stall_thresh_next = stall_thresh_reg;
        stall_delay_next = stall_delay_reg;
        external_shutdown_delay_next = external_shutdown_delay_reg;
        irq_enable_next = irq_enable_reg;
        irq_status_next = irq_status_reg;
        rdata_next = 32'h0000_0000;
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                OFF_CTRL: trip_reset_next = bus_i.wdata[CTRL_TRIP_RESET];
                OFF_INHIBIT: inhibit_next = bus_i.wdata[NUM_ALARMS-1:0];
                OFF_STALL_THRESH: stall_thresh_next = bus_i.wdata[11:0];
                OFF_STALL_DELAY: stall_delay_next = bus_i.wdata[15:0];
                OFF_REMOTE_DELAY: external_shutdown_delay_next = bus_i.wdata[15:0];
                OFF_IRQ_ENABLE: irq_enable_next = bus_i.wdata[1:0];
                OFF_IRQ_CLEAR: irq_status_next = irq_status_reg & ~bus_i.wdata[1:0];
                default: ;
            endcase
        end
        // set after clear so a same-cycle event survives
        if (newly_vec != '0) begin
            irq_status_next[IRQ_RAISE] = 1'b1;
        end
        if (clr) begin
            irq_status_next[IRQ_CLEARED] = 1'b1;
        end
        irq_next = (irq_status_next & irq_enable_next) != 2'b00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                OFF_CTRL: rdata_next = {31'h0, trip_reset_reg};
                OFF_INHIBIT: rdata_next = 32'(inhibit_reg);
                OFF_STALL_THRESH: rdata_next = {20'h0, stall_thresh_reg};
                OFF_STALL_DELAY: rdata_next = {16'h0, stall_delay_reg};
                OFF_REMOTE_DELAY: rdata_next = {16'h0, external_shutdown_delay_reg};
                OFF_HEALTH: rdata_next = {15'h0, healthy_reg, health_word_reg};
                OFF_FIRST: rdata_next = {16'h0, first_reg};
                OFF_LAST: rdata_next = {16'h0, last_reg};
                OFF_LATCHED: rdata_next = 32'(latched_reg);
                OFF_IRQ_STATUS: rdata_next = {30'h0, irq_status_reg};
                OFF_IRQ_ENABLE: rdata_next = {30'h0, irq_enable_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_reset_reg <= RST_TRIP_RESET;
            inhibit_reg <= '0;
            stall_thresh_reg <= RST_STALL_THRESH;
            stall_delay_reg <= RST_STALL_DELAY;
            external_shutdown_delay_reg <= RST_REMOTE_DELAY;
            irq_enable_reg <= 2'b00;
            irq_status_reg <= 2'b00;
            irq_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            trip_reset_reg <= trip_reset_next;
            inhibit_reg <= inhibit_next;
            stall_thresh_reg <= stall_thresh_next;
            stall_delay_reg <= stall_delay_next;
            external_shutdown_delay_reg <= external_shutdown_delay_next;
            irq_enable_reg <= irq_enable_next;
            irq_status_reg <= irq_status_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign healthy_o = healthy_reg;
    assign trip_o = trip_reg;
    assign irq_o = irq_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    health_word_a: assert property (
        health_word_reg == dtam_health_of(latched_reg & ~inhibit_reg))
        else $error("health word does not match latched alarms");
    first_hold_a: assert property (first_valid_reg && !clr |=> $stable(first_reg))
        else $error("first alarm changed while held");
    last_alarm_a: assert property (newly_vec != '0
        |=> last_reg == dtam_pick_code($past(newly_vec)))
        else $error("last alarm not updated");
    field_fail_a: assert property (fault_ready && field_low && !inhibit_reg[A_FIELD]
        |=> latched_reg[A_FIELD])
        else $error("field fail not latched");
    inhibit_mask_a: assert property ((det_vec & inhibit_reg) != '0 && active_vec == '0
        && (latched_reg & ~inhibit_reg) == '0 && !bus_i.wr |=> healthy_reg)
        else $error("inhibited alarm caused a trip");
    stall_inhibit_a: assert property (inhibit_reg[A_STALL] && det_vec[A_STALL]
        && active_vec == '0 && (latched_reg & ~inhibit_reg) == '0 && !bus_i.wr |=> !trip_reg)
        else $error("inhibited stall opened contactor");
    link_slave_a: assert property (!fs.link_slave |-> !det_vec[A_LINK])
        else $error("link receive alarm outside slave role");
    encoder_sel_a: assert property (!fs.encoder_selected |-> !det_vec[A_ENCODER])
        else $error("encoder alarm without encoder feedback");
    stall_cause_a: assert property ($rose(stall_done) |-> $past(stall_cond)
        && $past(u_stall_timer.count_reg) >= $past(stall_delay_reg))
        else $error("stall raised without persistent condition");
    remote_cause_a: assert property ($rose(remote_done) |-> $past(fs.raw_alarm[A_REMOTE]))
        else $error("remote trip raised without request");
    hold_latched_a: assert property (!trip_reset_reg && !bus_i.wr && latched_reg != '0
        |=> latched_reg != '0)
        else $error("latched faults lost with trip reset false");
    healthy_out_a: assert property (healthy_reg == ((latched_reg & ~inhibit_reg) == '0))
        else $error("healthy output disagrees with latched alarms");
    clear_effect_a: assert property (clr && active_vec == '0
        |=> health_word_reg == 16'h0000 && !first_valid_reg && last_reg == $past(last_reg))
        else $error("clear did not rearm alarm stores");
endmodule

//--- verilog/dtam_pkg.sv
// Function
// - first alarm code captured and held
// - last alarm holds most recent code
// - single-bit alarm codes per fixed table
// - extended alarm codes per fixed table
// - field fail below 6% current, 12% voltage
// - inhibit bit 1 masks alarm and trip
// - inhibited stall never opens main contactor
// - link receive error only as slave
// - stall: current over threshold, zero speed, setpoint
// - trip reset false keeps faults latched
// - remote trip waits configurable delay first
// - encoder alarm needs encoder feedback selected
package dtam_pkg;
    localparam int NUM_ALARMS = 19;
    localparam int A_FIELD = 0;
    localparam int A_ENCODER = 7;
    localparam int A_LINK = 9;
    localparam int A_STALL = 10;
    localparam int A_REMOTE = 16;
    localparam logic [7:0] FIELD_MIN_CUR_PCT = 8'h06;
    localparam logic [7:0] FIELD_MIN_VOLT_PCT = 8'h0C;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INHIBIT = 8'h04;
    localparam logic [7:0] OFF_STALL_THRESH = 8'h08;
    localparam logic [7:0] OFF_STALL_DELAY = 8'h0C;
    localparam logic [7:0] OFF_REMOTE_DELAY = 8'h10;
    localparam logic [7:0] OFF_HEALTH = 8'h14;
    localparam logic [7:0] OFF_FIRST = 8'h18;
    localparam logic [7:0] OFF_LAST = 8'h1C;
    localparam logic [7:0] OFF_LATCHED = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h2C;
    localparam int CTRL_TRIP_RESET = 0;
    localparam int CTRL_SOFT_CLEAR = 1;
    localparam int HEALTH_HEALTHY = 16;
    localparam int IRQ_RAISE = 0;
    localparam int IRQ_CLEARED = 1;
    localparam logic RST_TRIP_RESET = 1'b1;
    localparam logic [11:0] RST_STALL_THRESH = 12'h800;
    localparam logic [15:0] RST_STALL_DELAY = 16'h000A;
    localparam logic [15:0] RST_REMOTE_DELAY = 16'h000A;
    localparam logic [15:0] FIELD_FAIL_CODE = 16'h0001;

    typedef struct packed {
        logic run_input_terminal;
        logic voltage_mode;
        logic link_slave;
        logic encoder_selected;
        logic speed_zero;
        logic setpoint_zero;
        logic [7:0] field_current_pct;
        logic [11:0] armature_current;
        logic [NUM_ALARMS-1:0] raw_alarm;
    } dtam_fault_in_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dtam_bus_req_t;

    function automatic logic [15:0] dtam_code_of(input int idx);
        logic [15:0] c;
        c = 16'h0000;
        unique case (idx)
            0: c = FIELD_FAIL_CODE;
            1: c = 16'h0002;
            2: c = 16'h0004;
            3: c = 16'h0008;
            4: c = 16'h0010;
            5: c = 16'h0020;
            6: c = 16'h0040;
            7: c = 16'h0080;
            8: c = 16'h0200;
            9: c = 16'h0400;
            10: c = 16'h1000;
            11: c = 16'h2000;
            12: c = 16'h8000;
            13: c = 16'hF001;
            14: c = 16'hF400;
            15: c = 16'hF005;
            16: c = 16'hF006;
            17: c = 16'hFF05;
            18: c = 16'hFF06;
            default: c = 16'h0000;
        endcase
        return c;
    endfunction

    function automatic logic [15:0] dtam_health_of(input logic [NUM_ALARMS-1:0] v);
        logic [15:0] h;
        h = 16'h0000;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (v[i]) begin
                h = h | dtam_code_of(i);
            end
        end
        return h;
    endfunction

    // lowest index wins when several alarms appear in one cycle
    function automatic logic [15:0] dtam_pick_code(input logic [NUM_ALARMS-1:0] v);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = dtam_code_of(i);
            end
        end
        return c;
    endfunction
endpackage

//--- verilog/dtam_sync.sv
`timescale 1ns/1ps
module dtam_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d_i;
        q_next = meta_reg;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

//--- verilog/dtam_delay_timer.sv
`timescale 1ns/1ps
module dtam_delay_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cond_i,
    input wire logic tick_i,
    input wire logic [WIDTH-1:0] limit_i,
    output logic done_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic done_reg;
    logic done_next;

    // any break in the condition restarts the wait from zero
    always_comb begin
        count_next = count_reg;
        done_next = done_reg;
        if (!cond_i) begin
            count_next = '0;
            done_next = 1'b0;
        end else if (count_reg >= limit_i) begin
            done_next = 1'b1;
        end else if (tick_i) begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;
endmodule

//--- bench/dtam_fault_model.sv
`timescale 1ns/1ps
module dtam_fault_model (
    input wire logic clk_i,
    input wire dtam_pkg::dtam_fault_in_t want_i,
    input wire logic stall_i,
    output dtam_pkg::dtam_fault_in_t fault_o
);
    import dtam_pkg::*;

    dtam_fault_in_t sensed;

    always_comb begin
        sensed = want_i;
        sensed.speed_zero = stall_i;
        sensed.armature_current = stall_i ? 12'hFFF : 12'h100;
    end

    // sensors update just after the edge, never in step with the sampler
    always @(posedge clk_i) begin
        fault_o <= sensed;
    end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dtam_pkg::*;

    localparam logic [15:0] CODES [19] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0200, 16'h0400, 16'h1000,
        16'h2000, 16'h8000, 16'hF001, 16'hF400, 16'hF005, 16'hF006, 16'hFF05, 16'hFF06};
    localparam logic [7:0] FPCT [4] = '{8'h05, 8'h06, 8'h0B, 8'h0C};

    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic stall = 1'b0;
    dtam_fault_in_t want;
    dtam_fault_in_t fault;
    dtam_bus_req_t bus;
    logic [31:0] rdata_o;
    logic healthy_o;
    logic trip_o;
    logic irq_o;
    int mismatches = 0;
    int check_count = 0;

    always #50 clk_i = ~clk_i;

    dtam_fault_model u_dtam_fault_model (.clk_i(clk_i), .want_i(want), .stall_i(stall),
        .fault_o(fault));

    // short prescaler keeps the millisecond delays cheap to simulate
    dtam_alarm_manager #(.TICK_CYCLES(4)) u_dtam_alarm_manager (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .fault_i(fault), .bus_i(bus), .rdata_o(rdata_o),
        .healthy_o(healthy_o), .trip_o(trip_o), .irq_o(irq_o));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(negedge clk_i);
        check(rdata_o, exp);
    endtask

    task automatic pins(input logic h);
        @(negedge clk_i);
        check({30'h0, healthy_o, trip_o}, {30'h0, h, ~h});
    endtask

    task automatic irqc(input logic q);
        @(negedge clk_i);
        check({31'h0, irq_o}, {31'h0, q});
    endtask

    task automatic al(input int i, input logic v);
        @(posedge clk_i);
        want.raw_alarm[i] <= v;
    endtask

    task automatic run(input logic v);
        @(posedge clk_i);
        want.run_input_terminal <= v;
        cyc(6);
    endtask

    // raw pins must be quiet first, a clear keeps whatever is still active
    task automatic clr();
        cyc(4);
        wr(OFF_CTRL, 32'h3);
        cyc(2);
    endtask

    initial begin
        cyc(5000);
        mismatches++;
        final_report();
    end

    initial begin
        want = '0;
        want.field_current_pct = 8'h32;
        want.setpoint_zero = 1'b1;
        want.link_slave = 1'b1;
        want.encoder_selected = 1'b1;
        bus = '0;
        cyc(10);
        rst_b_i <= 1'b1;
        cyc(3);
        rd(OFF_CTRL, 32'h1);
        rd(OFF_INHIBIT, 32'h0);
        rd(OFF_STALL_THRESH, 32'h800);
        rd(OFF_STALL_DELAY, 32'hA);
        rd(OFF_REMOTE_DELAY, 32'hA);
        rd(OFF_HEALTH, 32'h10000);
        rd(8'h30, 32'h0);
        wr(OFF_HEALTH, 32'h0);
        rd(OFF_HEALTH, 32'h10000);
        pins(1'b1);
        $display("test reset done");

        for (int i = 1; i < NUM_ALARMS; i++) begin
            if (i != A_STALL) begin
                al(i, 1'b1);
                cyc(60);
                rd(OFF_HEALTH, {16'h0, CODES[i]});
                rd(OFF_FIRST, {16'h0, CODES[i]});
                rd(OFF_LAST, {16'h0, CODES[i]});
                pins(1'b0);
                al(i, 1'b0);
                clr();
                rd(OFF_HEALTH, 32'h10000);
                rd(OFF_FIRST, 32'h0);
                rd(OFF_LAST, {16'h0, CODES[i]});
            end
        end
        $display("test codes done");

        al(3, 1'b1);
        cyc(6);
        al(5, 1'b1);
        cyc(6);
        rd(OFF_HEALTH, 32'h28);
        rd(OFF_FIRST, 32'h8);
        rd(OFF_LAST, 32'h20);
        rd(OFF_LATCHED, 32'h28);
        al(3, 1'b0);
        al(5, 1'b0);
        clr();
        rd(OFF_FIRST, 32'h0);
        rd(OFF_LAST, 32'h20);
        $display("test first last done");

        @(posedge clk_i);
        want.link_slave <= 1'b0;
        want.encoder_selected <= 1'b0;
        want.raw_alarm[A_LINK] <= 1'b1;
        want.raw_alarm[A_ENCODER] <= 1'b1;
        cyc(8);
        pins(1'b1);
        @(posedge clk_i);
        want.raw_alarm[A_LINK] <= 1'b0;
        want.raw_alarm[A_ENCODER] <= 1'b0;
        $display("test roles done");

        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            want.voltage_mode <= k[1];
            want.field_current_pct <= FPCT[k];
            cyc(8);
            pins(k[0]);
            @(posedge clk_i);
            want.field_current_pct <= 8'h32;
            clr();
        end
        $display("test field done");

        wr(OFF_INHIBIT, 32'h409);
        wr(OFF_STALL_DELAY, 32'h4);
        @(posedge clk_i);
        want.field_current_pct <= 8'h05;
        want.raw_alarm[3] <= 1'b1;
        want.setpoint_zero <= 1'b0;
        stall <= 1'b1;
        cyc(40);
        pins(1'b1);
        rd(OFF_HEALTH, 32'h10000);
        @(posedge clk_i);
        want.field_current_pct <= 8'h32;
        want.raw_alarm[3] <= 1'b0;
        stall <= 1'b0;
        cyc(4);
        wr(OFF_INHIBIT, 32'h0);
        clr();
        $display("test inhibit done");

        @(posedge clk_i);
        want.setpoint_zero <= 1'b1;
        stall <= 1'b1;
        cyc(40);
        pins(1'b1);
        wr(OFF_STALL_THRESH, 32'hFFF);
        rd(OFF_STALL_THRESH, 32'hFFF);
        @(posedge clk_i);
        want.setpoint_zero <= 1'b0;
        cyc(40);
        pins(1'b1);
        @(posedge clk_i);
        stall <= 1'b0;
        cyc(4);
        wr(OFF_STALL_THRESH, 32'h800);
        @(posedge clk_i);
        stall <= 1'b1;
        cyc(8);
        @(posedge clk_i);
        stall <= 1'b0;
        cyc(2);
        @(posedge clk_i);
        stall <= 1'b1;
        cyc(8);
        pins(1'b1);
        cyc(30);
        pins(1'b0);
        rd(OFF_HEALTH, 32'h1000);
        @(posedge clk_i);
        stall <= 1'b0;
        clr();
        $display("test stall done");

        wr(OFF_REMOTE_DELAY, 32'h8);
        al(A_REMOTE, 1'b1);
        cyc(20);
        pins(1'b1);
        cyc(30);
        pins(1'b0);
        al(A_REMOTE, 1'b0);
        clr();
        $display("test remote delay done");

        wr(OFF_CTRL, 32'h0);
        rd(OFF_CTRL, 32'h0);
        al(3, 1'b1);
        cyc(6);
        al(3, 1'b0);
        cyc(4);
        run(1'b1);
        run(1'b0);
        run(1'b1);
        pins(1'b0);
        wr(OFF_CTRL, 32'h1);
        cyc(2);
        pins(1'b1);
        run(1'b0);
        al(3, 1'b1);
        cyc(6);
        al(3, 1'b0);
        cyc(4);
        pins(1'b0);
        run(1'b1);
        pins(1'b1);
        $display("test trip reset done");

        wr(OFF_IRQ_CLEAR, 32'h3);
        wr(OFF_IRQ_ENABLE, 32'h1);
        cyc(2);
        irqc(1'b0);
        al(5, 1'b1);
        cyc(6);
        irqc(1'b1);
        rd(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'h1);
        irqc(1'b0);
        wr(OFF_IRQ_ENABLE, 32'h0);
        al(5, 1'b0);
        clr();
        irqc(1'b0);
        rd(OFF_IRQ_STATUS, 32'h2);
        wr(OFF_IRQ_ENABLE, 32'h2);
        irqc(1'b1);
        rd(OFF_IRQ_ENABLE, 32'h2);
        wr(OFF_IRQ_CLEAR, 32'h2);
        irqc(1'b0);
        $display("test interrupt done");
        final_report();
    end
endmodule
